// ===== tgcc_channel.sv
// one timer channel: general compare/capture registers, counter, status
//
// Overview of operation
// - 16-bit register, compare or capture per io control
// - compare against count on every update
// - compare match sets flag a or b
// - match output action chosen in io control
// - capture on rising, falling or both edges
// - valid edge latches current count
// - flag set with the capture latch
// - pwm modes ignore io control settings
// - word or byte access over 16-bit bus
// - reset/standby: compare, no output action
// - reset/standby load all ones
// - buffer a and b only in channels 3, 4
// - counter zero on reset/standby, register-clearable
`timescale 1ns/1ps
`default_nettype none
module tgcc_channel
    import tgcc_pkg::*;
#(
    parameter int unsigned HAS_BUFFER = 0
) (
    input  wire logic               ref_clk,
    input  wire logic               resetn,
    input  wire logic               standby,
    input  wire logic               count_tick,
    input  wire logic [1:0]         cap_pin,
    input  wire logic               cpu_sel,
    input  wire logic               cpu_wr,
    input  wire logic [2:0]         cpu_addr,
    input  wire logic [1:0]         cpu_be,
    input  wire logic [TGCC_DW-1:0] cpu_wdata,
    output var  logic [TGCC_DW-1:0] cpu_rdata,
    output var  logic [1:0]         match_flag,
    output var  logic [1:0]         cmp_out
);

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    if (HAS_BUFFER > 1) begin : g_bad_param
        $error("HAS_BUFFER must be 0 or 1");
    end

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [7:0]         io_control_ff;
    logic [2:0]         control_ff;
    logic [TGCC_DW-1:0] count_ff;
    logic               upd_ff;
    logic [TGCC_DW-1:0] buffer_a_ff;
    logic [TGCC_DW-1:0] buffer_b_ff;
    logic [TGCC_DW-1:0] nxt_rdata;
    logic [TGCC_DW-1:0] gen_val [2];
    logic [1:0]         hit;
    logic [1:0]         edge_pulse;
    logic [1:0]         cap_mode;
    logic [1:0]         cap_evt;
    logic [1:0]         gen_wr;
    logic [1:0]         flag_clr;
    logic               pwm_mode;
    logic               wr_lo;
    logic               wr_hi;
    logic               count_clear;

    assign wr_lo    = cpu_sel & cpu_wr & cpu_be[0];
    assign wr_hi    = cpu_sel & cpu_wr & cpu_be[1];
    assign pwm_mode = control_ff[CTRL_PWM_BIT];
    assign gen_wr   = {cpu_addr == IDX_GEN_B, cpu_addr == IDX_GEN_A};

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    // compare function, no action, after reset or standby
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            io_control_ff <= IOC_RESET;
        end else if (standby) begin
            io_control_ff <= IOC_RESET;
        end else if (wr_lo && cpu_addr == IDX_IO_CONTROL) begin
            io_control_ff <= cpu_wdata[7:0];
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            control_ff <= CTRL_RESET;
        end else if (standby) begin
            control_ff <= CTRL_RESET;
        end else if (wr_lo && cpu_addr == IDX_CONTROL) begin
            control_ff <= cpu_wdata[2:0];
        end
    end

    // ------------------------------------------------------------
    // channel counter
    // ------------------------------------------------------------
    assign count_clear = (control_ff[CTRL_CLR_LSB +: 2] == CLR_ON_A && hit[0])
                       | (control_ff[CTRL_CLR_LSB +: 2] == CLR_ON_B && hit[1]);

    // cleared on reset, standby and selected register event
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            count_ff <= COUNT_RESET;
            upd_ff   <= 1'b0;
        end else if (standby) begin
            count_ff <= COUNT_RESET;
            upd_ff   <= 1'b0;
        end else if (count_clear) begin
            count_ff <= COUNT_RESET;
            upd_ff   <= 1'b1;
        end else if (count_tick) begin
            count_ff <= count_ff + 16'h0001;
            upd_ff   <= 1'b1;
        end else begin
            if (wr_lo && cpu_addr == IDX_COUNT) begin
                count_ff[7:0] <= cpu_wdata[7:0];
            end
            if (wr_hi && cpu_addr == IDX_COUNT) begin
                count_ff[15:8] <= cpu_wdata[15:8];
            end
            upd_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // per-register logic, a then b
    // ------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_reg
        logic [2:0] field;
        assign field = io_control_ff[i*IOC_FIELD_STEP +: 3];

        // io control ignored while in a pwm mode
        assign cap_mode[i] = field[IOC_CAP_BIT] & ~pwm_mode;
        assign cap_evt[i]  = edge_pulse[i] & cap_mode[i];
        assign flag_clr[i] = wr_lo & (cpu_addr == IDX_STATUS) & ~cpu_wdata[i];

        tgcc_edge_detect u_edge (
            .ref_clk    (ref_clk),
            .resetn     (resetn),
            .cap_pin    (cap_pin[i]),
            .edge_sel   (field[1:0]),
            .edge_pulse (edge_pulse[i])
        );

        // one general register in compare or capture
        tgcc_general_reg u_gen (
            .ref_clk    (ref_clk),
            .resetn     (resetn),
            .standby    (standby),
            .wr_lo      (wr_lo & gen_wr[i]),
            .wr_hi      (wr_hi & gen_wr[i]),
            .wdata      (cpu_wdata),
            .capture    (cap_evt[i]),
            .count      (count_ff),
            .count_upd  (upd_ff),
            .compare_en (~cap_mode[i]),
            .value      (gen_val[i]),
            .hit        (hit[i])
        );

        // set wins over a write of zero
        always_ff @(posedge ref_clk or negedge resetn) begin
            if (!resetn) begin
                match_flag[i] <= 1'b0;
            end else if (standby) begin
                match_flag[i] <= 1'b0;
            end else if (hit[i]) begin
                match_flag[i] <= 1'b1;
            end else if (flag_clr[i]) begin
                match_flag[i] <= 1'b0;
            end
        end

        // output action on compare match; pwm drive lives elsewhere
        always_ff @(posedge ref_clk or negedge resetn) begin
            if (!resetn) begin
                cmp_out[i] <= 1'b0;
            end else if (hit[i] && !cap_mode[i] && !pwm_mode) begin
                case (field[1:0])
                    ACT_LOW: begin
                        cmp_out[i] <= 1'b0;
                    end
                    ACT_HIGH: begin
                        cmp_out[i] <= 1'b1;
                    end
                    ACT_TOGGLE: begin
                        cmp_out[i] <= ~cmp_out[i];
                    end
                    default: begin
                        cmp_out[i] <= cmp_out[i];
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // buffer registers
    // ------------------------------------------------------------
    // storage only where the channel has buffers
    if (HAS_BUFFER == 1) begin : g_buf
        always_ff @(posedge ref_clk or negedge resetn) begin
            if (!resetn) begin
                buffer_a_ff <= BUF_RESET;
                buffer_b_ff <= BUF_RESET;
            end else begin
                if (wr_lo && cpu_addr == IDX_BUF_A) begin
                    buffer_a_ff[7:0] <= cpu_wdata[7:0];
                end
                if (wr_hi && cpu_addr == IDX_BUF_A) begin
                    buffer_a_ff[15:8] <= cpu_wdata[15:8];
                end
                if (wr_lo && cpu_addr == IDX_BUF_B) begin
                    buffer_b_ff[7:0] <= cpu_wdata[7:0];
                end
                if (wr_hi && cpu_addr == IDX_BUF_B) begin
                    buffer_b_ff[15:8] <= cpu_wdata[15:8];
                end
            end
        end
    end else begin : g_nobuf
        assign buffer_a_ff = BUF_RESET;
        assign buffer_b_ff = BUF_RESET;
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // full word is returned; cpu picks its byte
    always_comb begin
        case (cpu_addr)
            IDX_IO_CONTROL: begin
                nxt_rdata = {8'h00, io_control_ff};
            end
            IDX_STATUS: begin
                nxt_rdata = {14'h0000, match_flag};
            end
            IDX_COUNT: begin
                nxt_rdata = count_ff;
            end
            IDX_CONTROL: begin
                nxt_rdata = {13'h0000, control_ff};
            end
            IDX_GEN_A: begin
                nxt_rdata = gen_val[0];
            end
            IDX_GEN_B: begin
                nxt_rdata = gen_val[1];
            end
            IDX_BUF_A: begin
                nxt_rdata = buffer_a_ff;
            end
            default: begin
                nxt_rdata = buffer_b_ff;
            end
        endcase
    end

    // rdata holds between reads so a slow cpu can sample late
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cpu_rdata <= 16'h0000;
        end else if (cpu_sel && !cpu_wr) begin
            cpu_rdata <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    cmp_flag_a: assert property (
        upd_ff && !cap_mode[0] && count_ff == gen_val[0] && !standby |=> match_flag[0])
        else $error("compare match a did not set its flag");

    cap_flag_a: assert property (
        cap_evt[1] && !standby |=> match_flag[1] && gen_val[1] == $past(count_ff))
        else $error("capture b did not latch and flag together");

    flag_sticky_a: assert property (
        match_flag[0] && !flag_clr[0] && !standby |=> match_flag[0])
        else $error("flag a dropped without a clear");

    set_wins_a: assert property (
        hit[0] && flag_clr[0] && !standby |=> match_flag[0])
        else $error("clear beat a simultaneous event");

    pwm_ignore_a: assert property (
        pwm_mode && !standby && !(wr_lo || wr_hi) |=> $stable(gen_val[1]))
        else $error("capture taken in pwm mode");

    action_high_a: assert property (
        hit[0] && !cap_mode[0] && !pwm_mode && io_control_ff[1:0] == ACT_HIGH
        |=> cmp_out[0])
        else $error("set-on-match action not applied");

    standby_init_a: assert property (
        standby |=> io_control_ff == IOC_RESET && count_ff == COUNT_RESET)
        else $error("standby did not restore compare mode and zero count");

    count_clr_a: assert property (
        count_clear && !standby |=> count_ff == COUNT_RESET)
        else $error("counter clearing function failed");

    no_buffer_a: assert property (
        HAS_BUFFER == 0 && cpu_sel && !cpu_wr && cpu_addr >= IDX_BUF_A
        |=> cpu_rdata == 16'h0000)
        else $error("absent buffer did not read zero");

endmodule
`default_nettype wire

// ===== tgcc_edge_detect.sv
// synchroniser and valid-edge detector for one capture input
`timescale 1ns/1ps
`default_nettype none
module tgcc_edge_detect
    import tgcc_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic       cap_pin,
    input  wire logic [1:0] edge_sel,
    output var  logic       edge_pulse
);

    logic sync1_ff;
    logic sync2_ff;
    logic prev_ff;
    logic rise;
    logic fall;
    logic nxt_edge_pulse;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff  <= 1'b0;
        end else begin
            sync1_ff <= cap_pin;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    assign rise = sync2_ff & ~prev_ff;
    assign fall = ~sync2_ff & prev_ff;

    always_comb begin
        if (edge_sel[1]) begin
            nxt_edge_pulse = rise | fall;
        end else if (edge_sel == EDGE_FALL) begin
            nxt_edge_pulse = fall;
        end else begin
            nxt_edge_pulse = rise;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            edge_pulse <= 1'b0;
        end else begin
            edge_pulse <= nxt_edge_pulse;
        end
    end

    sequence rise_seen_s;
        !prev_ff && sync2_ff;
    endsequence

    sequence fall_seen_s;
        prev_ff && !sync2_ff;
    endsequence

    property sel_edge_p(logic [1:0] sel, logic want);
        @(posedge ref_clk) disable iff (!resetn)
            (edge_sel == sel) ##0 (rise_seen_s or fall_seen_s) |=> (edge_pulse == $past(want));
    endproperty

    rise_edge_a: assert property (sel_edge_p(EDGE_RISE, rise))
        else $error("rising-edge select pulse mismatch");
    fall_edge_a: assert property (sel_edge_p(EDGE_FALL, fall))
        else $error("falling-edge select pulse mismatch");

endmodule
`default_nettype wire

// ===== tgcc_general_reg.sv
// one general register: byte writes, capture load, compare hit
`timescale 1ns/1ps
`default_nettype none
module tgcc_general_reg
    import tgcc_pkg::*;
(
    input  wire logic               ref_clk,
    input  wire logic               resetn,
    input  wire logic               standby,
    input  wire logic               wr_lo,
    input  wire logic               wr_hi,
    input  wire logic [TGCC_DW-1:0] wdata,
    input  wire logic               capture,
    input  wire logic [TGCC_DW-1:0] count,
    input  wire logic               count_upd,
    input  wire logic               compare_en,
    output var  logic [TGCC_DW-1:0] value,
    output logic                    hit
);

    // capture loads count, beats cpu write
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            value <= GEN_RESET;
        end else if (standby) begin
            value <= GEN_RESET;
        end else if (capture) begin
            value <= count;
        end else begin
            if (wr_lo) begin
                value[7:0] <= wdata[7:0];
            end
            if (wr_hi) begin
                value[15:8] <= wdata[15:8];
            end
        end
    end

    assign hit = capture | (compare_en & count_upd & (count == value));

    cap_latch_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        capture && !standby |=> value == $past(count))
        else $error("capture did not latch the count");

    lane_keep_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        wr_lo && !wr_hi && !capture && !standby |=> value[15:8] == $past(value[15:8]))
        else $error("low-byte write disturbed high byte");

    standby_ones_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        standby |=> value == GEN_RESET)
        else $error("general register not all ones after standby");

endmodule
`default_nettype wire

// ===== tgcc_pin_model.sv
// far-side model: capture pin source with prompt or slow edges
`timescale 1ns/1ps
`default_nettype none
module tgcc_pin_model (
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic [1:0] pin_req,
    input  wire logic       slow,
    output var  logic [1:0] cap_pin
);
    logic [1:0] dly_ff;
    logic [1:0] pin_ff;

    // extra stage only delays an edge; each level still lasts whole clocks
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            dly_ff <= 2'h0;
        end else begin
            dly_ff <= pin_req;
        end
    end

    // pins change only on a clock edge, so no level is shorter than a cycle
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pin_ff <= 2'h0;
        end else begin
            pin_ff <= slow ? dly_ff : pin_req;
        end
    end

    assign cap_pin = pin_ff;
endmodule
`default_nettype wire

// ===== tgcc_pkg.sv
// constants shared by the general compare/capture register block
package tgcc_pkg;

    // ------------------------------------------------------------
    // data path
    // ------------------------------------------------------------
    localparam int unsigned TGCC_DW = 16;

    // ------------------------------------------------------------
    // register word indices on the internal 16-bit bus
    // ------------------------------------------------------------
    localparam logic [2:0] IDX_IO_CONTROL = 3'h0;
    localparam logic [2:0] IDX_STATUS     = 3'h1;
    localparam logic [2:0] IDX_COUNT      = 3'h2;
    localparam logic [2:0] IDX_CONTROL    = 3'h3;
    localparam logic [2:0] IDX_GEN_A      = 3'h4;
    localparam logic [2:0] IDX_GEN_B      = 3'h5;
    localparam logic [2:0] IDX_BUF_A      = 3'h6;
    localparam logic [2:0] IDX_BUF_B      = 3'h7;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned IOC_FIELD_STEP = 4;  // A at bits 2:0, B at bits 6:4
    localparam int unsigned IOC_CAP_BIT    = 2;  // within a field: 1 = capture
    localparam int unsigned CTRL_CLR_LSB   = 0;  // counter clear select, 2 bits
    localparam int unsigned CTRL_PWM_BIT   = 2;  // channel in a pwm mode

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] GEN_RESET   = 16'hffff;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] BUF_RESET   = 16'h0000;
    localparam logic [7:0]  IOC_RESET   = 8'h00;
    localparam logic [2:0]  CTRL_RESET  = 3'h0;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    localparam logic [1:0] ACT_NONE    = 2'h0;
    localparam logic [1:0] ACT_LOW     = 2'h1;
    localparam logic [1:0] ACT_HIGH    = 2'h2;
    localparam logic [1:0] ACT_TOGGLE  = 2'h3;
    localparam logic [1:0] EDGE_RISE   = 2'h0;
    localparam logic [1:0] EDGE_FALL   = 2'h1;
    localparam logic [1:0] CLR_NONE    = 2'h0;
    localparam logic [1:0] CLR_ON_A    = 2'h1;
    localparam logic [1:0] CLR_ON_B    = 2'h2;

endpackage

// ===== timer_general_compare_capture_regs_tb.sv
// self-checking bench for one channel of general compare/capture registers
`timescale 1ns/1ps
`default_nettype none
module timer_general_compare_capture_regs_tb
    import tgcc_pkg::*;
;
    logic               ref_clk    = 1'b0;
    logic               resetn     = 1'b0;
    logic               standby    = 1'b0;
    logic               count_tick = 1'b0;
    logic [1:0]         cap_pin;
    logic [1:0]         pin_req    = 2'h0;
    logic               slow       = 1'b0;
    logic               cpu_sel    = 1'b0;
    logic               cpu_wr     = 1'b0;
    logic [2:0]         cpu_addr   = 3'h0;
    logic [1:0]         cpu_be     = 2'h0;
    logic [TGCC_DW-1:0] cpu_wdata  = 16'h0000;
    logic [TGCC_DW-1:0] cpu_rdata;
    logic [1:0]         match_flag;
    logic [1:0]         cmp_out;
    int                 fail_count = 0;
    int                 tests_run  = 0;
    int                 n;
    logic [15:0]        rd, old, c, d;
    logic [2:0]         a;
    logic [1:0]         be;
    logic               lvl, hit;
    logic [1:0]         acts [5]    = '{ACT_HIGH, ACT_LOW, ACT_TOGGLE, ACT_NONE, ACT_TOGGLE};
    logic [2:0]         rst_idx [5] = '{IDX_GEN_A, IDX_GEN_B, IDX_IO_CONTROL, IDX_COUNT,
                                        IDX_STATUS};
    logic [15:0]        rst_val [5] = '{GEN_RESET, GEN_RESET, 16'h0000, COUNT_RESET, 16'h0000};

    always #50 ref_clk = ~ref_clk;

    tgcc_channel #(
        .HAS_BUFFER (1)
    ) i_tgcc_channel (
        .ref_clk    (ref_clk),
        .resetn     (resetn),
        .standby    (standby),
        .count_tick (count_tick),
        .cap_pin    (cap_pin),
        .cpu_sel    (cpu_sel),
        .cpu_wr     (cpu_wr),
        .cpu_addr   (cpu_addr),
        .cpu_be     (cpu_be),
        .cpu_wdata  (cpu_wdata),
        .cpu_rdata  (cpu_rdata),
        .match_flag (match_flag),
        .cmp_out    (cmp_out)
    );

    tgcc_pin_model i_tgcc_pin_model (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .pin_req (pin_req),
        .slow    (slow),
        .cap_pin (cap_pin)
    );

    // ------------------------------------------------------------
    // expectation helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] merge(logic [15:0] o, logic [15:0] v, logic [1:0] b);
        return {b[1] ? v[15:8] : o[15:8], b[0] ? v[7:0] : o[7:0]};
    endfunction

    function automatic logic next_lvl(logic [1:0] act, logic l);
        case (act)
            ACT_LOW:    return 1'b0;
            ACT_HIGH:   return 1'b1;
            ACT_TOGGLE: return ~l;
            default:    return l;
        endcase
    endfunction

    function automatic logic cap_hit(int m, logic rising);
        return (m == 0) ? rising : (m == 1) ? ~rising : 1'b1;
    endfunction

    // ------------------------------------------------------------
    // bus and check tasks
    // ------------------------------------------------------------
    task automatic summarize();
        $display("checks run %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus(input logic w, input logic [2:0] ad, input logic [1:0] b,
                       input logic [15:0] v);
        cpu_sel   = 1'b1;
        cpu_wr    = w;
        cpu_addr  = ad;
        cpu_be    = b;
        cpu_wdata = v;
        @(posedge ref_clk);
        #1;
        cpu_sel = 1'b0;
        rd      = cpu_rdata;
        @(posedge ref_clk);
        #1;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask

    task automatic tick(input int k);
        repeat (k) begin
            count_tick = 1'b1;
            cyc(1);
            count_tick = 1'b0;
            cyc(1);
        end
    endtask

    task automatic wait_flag(input logic exp);
        int k;
        k = 0;
        while (match_flag[1] !== 1'b1 && k < 12) begin
            cyc(1);
            k++;
        end
        chk("capture flag b", {15'h0, exp}, {15'h0, match_flag[1]});
        if (exp && k == 12) begin
            summarize();
        end
    endtask

    task automatic check_reset_table();
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, rst_idx[i], 2'h3, 16'h0000);
            chk("initial register value", rst_val[i], rd);
        end
        chk("flags at init", 16'h0, {14'h0, match_flag});
    endtask

    initial begin
        #6000000;
        fail_count++;
        $display("CHECK FAILED run length expected finish seen hang");
        summarize();
    end

    initial begin
        void'($urandom(55924));
        repeat (2) @(posedge ref_clk);
        #1;
        resetn = 1'b1;
        chk("cmp_out at reset", 16'h0, {14'h0, cmp_out});
        check_reset_table();
        $display("test reset done");

        for (int i = 0; i < 8; i++) begin
            a  = IDX_GEN_A + 3'($urandom_range(0, 3));
            d  = 16'($urandom());
            be = (i < 2) ? 2'h3 : 2'($urandom_range(1, 3));
            bus(1'b0, a, 2'h3, 16'h0000);
            old = rd;
            bus(1'b1, a, be, d);
            bus(1'b0, a, 2'h3, 16'h0000);
            chk("register readback", merge(old, d, be), rd);
        end
        $display("test access done");

        lvl = 1'b0;
        for (int i = 0; i < 5; i++) begin
            n = $urandom_range(1, 4);
            bus(1'b1, IDX_IO_CONTROL, 2'h1, {14'h0, acts[i]});
            bus(1'b1, IDX_COUNT, 2'h3, 16'h0000);
            bus(1'b1, IDX_GEN_A, 2'h3, 16'(n));
            bus(1'b1, IDX_STATUS, 2'h1, 16'h0000);
            tick(n - 1);
            cyc(4);
            chk("flag a before match", 16'h0, {15'h0, match_flag[0]});
            tick(1);
            cyc(3);
            lvl = next_lvl(acts[i], lvl);
            chk("compare flag a", 16'h1, {15'h0, match_flag[0]});
            chk("compare output a", {15'h0, lvl}, {15'h0, cmp_out[0]});
        end
        cyc(6);
        chk("flag a held", 16'h1, {15'h0, match_flag[0]});
        bus(1'b1, IDX_STATUS, 2'h1, 16'h0000);
        bus(1'b1, IDX_GEN_A, 2'h3, 16'(n + 1));
        count_tick = 1'b1;
        cyc(1);
        count_tick = 1'b0;
        // clear is taken on the very edge that sees the match
        bus(1'b1, IDX_STATUS, 2'h1, 16'h0000);
        chk("flag a set beats clear", 16'h1, {15'h0, match_flag[0]});
        bus(1'b1, IDX_STATUS, 2'h1, 16'h0000);
        chk("flag a cleared", 16'h0, {15'h0, match_flag[0]});
        bus(1'b1, IDX_CONTROL, 2'h1, {14'h0, CLR_ON_A});
        bus(1'b1, IDX_GEN_A, 2'h3, 16'h0002);
        bus(1'b1, IDX_COUNT, 2'h3, 16'h0000);
        tick(2);
        bus(1'b0, IDX_COUNT, 2'h3, 16'h0000);
        chk("count cleared by match a", COUNT_RESET, rd);
        bus(1'b1, IDX_CONTROL, 2'h1, 16'h0000);
        $display("test compare done");

        for (int m = 0; m < 3; m++) begin
            slow = m[0];
            bus(1'b1, IDX_IO_CONTROL, 2'h1, 16'h0040 | 16'(m << 4));
            for (int e = 0; e < 2; e++) begin
                c = 16'($urandom());
                bus(1'b1, IDX_COUNT, 2'h3, c);
                bus(1'b1, IDX_STATUS, 2'h1, 16'h0000);
                bus(1'b0, IDX_GEN_B, 2'h3, 16'h0000);
                old = rd;
                pin_req[1] = ~pin_req[1];
                hit = cap_hit(m, pin_req[1]);
                wait_flag(hit);
                bus(1'b0, IDX_GEN_B, 2'h3, 16'h0000);
                chk("capture value b", hit ? c : old, rd);
            end
        end
        $display("test capture done");

        bus(1'b1, IDX_CONTROL, 2'h1, 16'h0004);
        bus(1'b1, IDX_IO_CONTROL, 2'h1, 16'h0060);
        bus(1'b1, IDX_STATUS, 2'h1, 16'h0000);
        pin_req[1] = 1'b1;
        wait_flag(1'b0);
        pin_req[1] = 1'b0;
        cyc(8);
        bus(1'b1, IDX_CONTROL, 2'h1, 16'h0000);
        $display("test pwm done");

        bus(1'b1, IDX_IO_CONTROL, 2'h1, 16'h0045);
        bus(1'b1, IDX_COUNT, 2'h3, 16'($urandom()) | 16'h0001);
        bus(1'b1, IDX_GEN_A, 2'h3, 16'h0000);
        pin_req[1] = 1'b1;
        cyc(8);
        standby = 1'b1;
        cyc(2);
        standby = 1'b0;
        check_reset_table();
        resetn = 1'b0;
        cyc(2);
        resetn = 1'b1;
        chk("cmp_out after reset", 16'h0, {14'h0, cmp_out});
        check_reset_table();
        $display("test standby done");
        summarize();
    end
endmodule
`default_nettype wire
